/* File: bench/hmsp_host_model.sv */
// host processor model driving the parallel strobe bus
`default_nettype none
module hmsp_host_model (
    input wire logic clock,
    output var hmsp_pkg::hmsp_host_t host_pins,
    input wire logic [7:0] host_data_out,
    input wire logic host_data_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic rd_n = 1'b1;
    logic wr_n = 1'b1;
    logic channel_one_select_n = 1'b1;
    logic channel_two_select_n = 1'b1;
    logic addr = 1'b0;
    logic drv = 1'b0;
    logic [7:0] wd = 8'h00;
    logic [7:0] last = 8'h00;
    logic [7:0] bus;
    // released bus shows the inverse of the last value driven on it
    assign bus = host_data_oe ? host_data_out : (drv ? wd : ~last);
    assign host_pins = '{rd_n, wr_n, channel_one_select_n,
        channel_two_select_n, addr, bus};
    always @(posedge clock)
    begin
        if (host_data_oe === 1'b1 || drv)
        begin
            last <= bus;
        end
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // address line held across the write
    task automatic hwrite(input logic ch, input logic a,
                          input logic [7:0] d);
        channel_one_select_n = ch;
        channel_two_select_n = !ch;
        addr = a;
        wd = d;
        drv = 1'b1;
        cyc(1);
        wr_n = 1'b0;
        cyc(4);
        wr_n = 1'b1;
        cyc(4);
        drv = 1'b0;
        channel_one_select_n = 1'b1;
        channel_two_select_n = 1'b1;
        cyc(4);
    endtask

    // read strobe only, address picks status
    task automatic hread(input logic ch, input logic a,
                         output logic [7:0] d);
        channel_one_select_n = ch;
        channel_two_select_n = !ch;
        addr = a;
        cyc(1);
        rd_n = 1'b0;
        cyc(5);
        d = host_pins.data;
        rd_n = 1'b1;
        cyc(4);
        channel_one_select_n = 1'b1;
        channel_two_select_n = 1'b1;
        cyc(2);
    endtask
endmodule
`default_nettype wire

/* File: bench/hmsp_port_tb_top.sv */
// self-checking bench for the host mailbox status port
`default_nettype none
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin \
error_cnt++; $display("CHECK FAILED %s exp %0h got %0h", n, e, s); \
end end
module hmsp_port_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic standby = 1'b0;
    logic clk_en = 1'b1;
    logic [7:0] ub [2] = '{8'h00, 8'h00};
    hmsp_pkg::hmsp_sbus_t sbus = '0;
    hmsp_pkg::hmsp_host_t host_pins;
    logic [7:0] sl_rdata;
    logic [7:0] host_data_out;
    logic host_data_oe;
    logic host_port_active;
    logic [1:0] in_full_irq;
    int error_cnt = 0;
    int total_checks = 0;
    logic [7:0] q;
    logic [7:0] d;
    logic [7:0] o;
    logic [7:0] u;
    logic [7:0] s;

    always #10 clock = ~clock;

    hmsp_port hmsp_port_i (
        .clock(clock),
        .reset(reset),
        .clk_en(clk_en),
        .standby(standby),
        .sbus(sbus),
        .sl_rdata(sl_rdata),
        .host_pins(host_pins),
        .host_data_out(host_data_out),
        .host_data_oe(host_data_oe),
        .host_port_active(host_port_active),
        .in_full_irq(in_full_irq)
    );

    hmsp_host_model hmsp_host_model_i (
        .clock(clock),
        .host_pins(host_pins),
        .host_data_out(host_data_out),
        .host_data_oe(host_data_oe)
    );

    task automatic results;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // one slave access; entered and left just after an edge
    task automatic sacc(input logic w, input logic [15:0] a,
                        input logic [7:0] wd, output logic [7:0] rq);
        sbus = '{!w, w, a, wd};
        @(posedge clock);
        #1;
        sbus.rd = 1'b0;
        sbus.wr = 1'b0;
        rq = sl_rdata;
        @(posedge clock);
        #1;
    endtask

    // k: 0 inbound, 1 outbound, 2 status
    function automatic logic [15:0] adr(input logic ch, input int k);
        return (ch ? hmsp_pkg::IN2_ADDR : hmsp_pkg::IN1_ADDR) + 16'(k);
    endfunction

    function automatic logic [7:0] stv(input logic [7:0] usr,
                                       input logic c, input logic i,
                                       input logic f);
        return (usr & hmsp_pkg::USER_MASK) | {4'h0, c, 1'b0, i, f};
    endfunction

    initial
    begin
        #200us;
        error_cnt++;
        results();
    end

    initial
    begin
        void'($urandom(32'hA8FA5F4A));
        repeat (2) @(posedge clock);
        #1;
        reset = 1'b0;
        sacc(0, hmsp_pkg::SYSCTL_ADDR, 8'h00, q);
        `CHK("sysctl", hmsp_pkg::SYSCTL_RESET, q)
        sacc(0, hmsp_pkg::ST1_ADDR, 8'h00, q);
        `CHK("gated", 8'h00, q)
        `CHK("inactive", 1'b0, host_port_active)
        sacc(1, hmsp_pkg::SYSCTL_ADDR, 8'h0B, q);
        `CHK("active", 1'b1, host_port_active)
        for (int ch = 0; ch < 2; ch++)
        begin
            sacc(0, adr(ch, 2), 8'h00, q);
            `CHK("st reset", hmsp_pkg::STATUS_RESET, q)
        end
        sacc(0, hmsp_pkg::HICTL_ADDR, 8'h00, q);
        `CHK("ictl", hmsp_pkg::HICTL_RESET, q)
        sacc(1, hmsp_pkg::HICTL_ADDR, 8'h06, q);
        for (int i = 0; i < 4; i++)
        begin
            d = 8'($urandom);
            o = 8'($urandom);
            u = 8'($urandom);
            hmsp_host_model_i.hread(i[1], 1'b1, q);
            `CHK("poll in", 1'b0, q[hmsp_pkg::IN_FULL_BIT])
            hmsp_host_model_i.hwrite(i[1], i[0], d);
            repeat (10) @(posedge clock);
            #1;
            sacc(0, adr(i[1], 2), 8'h00, q);
            `CHK("st in", stv(ub[i[1]], i[0], 1, 0), q)
            `CHK("irq on", 1'b1, in_full_irq[i[1]])
            sacc(0, adr(i[1], 0), 8'h00, q);
            `CHK("inbound", d, q)
            sacc(0, adr(i[1], 2), 8'h00, q);
            `CHK("st read", stv(ub[i[1]], i[0], 0, 0), q)
            `CHK("irq off", 1'b0, in_full_irq[i[1]])
            sacc(1, adr(i[1], 2), u, q);
            ub[i[1]] = u;
            sacc(1, adr(i[1], 1), o, q);
            sacc(0, adr(i[1], 2), 8'h00, q);
            s = stv(u, i[0], 0, 1);
            `CHK("st user", s, q)
            hmsp_host_model_i.hread(i[1], 1'b1, q);
            `CHK("host st", s, q)
            sacc(0, adr(i[1], 1), 8'h00, q);
            `CHK("out slave", o, q)
            hmsp_host_model_i.hread(i[1], 1'b0, q);
            `CHK("out host", o, q)
            `CHK("oe off", 1'b0, host_data_oe)
            sacc(0, adr(i[1], 2), 8'h00, q);
            `CHK("st host rd", stv(u, i[0], 0, 0), q)
        end
        // frozen clock enable must drop a slave write
        clk_en = 1'b0;
        sacc(1, adr(1, 2), 8'hFF, q);
        clk_en = 1'b1;
        sacc(0, adr(1, 2), 8'h00, q);
        `CHK("frozen", stv(ub[1], 1, 0, 0), q)
        // masked interrupt, slave write to inbound refused
        sacc(1, hmsp_pkg::HICTL_ADDR, 8'h00, q);
        d = 8'($urandom);
        hmsp_host_model_i.hwrite(1'b0, 1'b0, d);
        repeat (10) @(posedge clock);
        #1;
        `CHK("irq mask", 2'b00, in_full_irq)
        sacc(1, adr(0, 0), ~d, q);
        sacc(0, adr(0, 0), 8'h00, q);
        `CHK("in ro", d, q)
        sacc(1, adr(0, 2), 8'hFF, q);
        standby = 1'b1;
        @(posedge clock);
        #1;
        standby = 1'b0;
        sacc(0, adr(0, 2), 8'h00, q);
        `CHK("st stby", hmsp_pkg::STATUS_RESET, q)
        sacc(0, adr(1, 2), 8'h00, q);
        `CHK("st2 stby", hmsp_pkg::STATUS_RESET, q)
        sacc(0, hmsp_pkg::HICTL_ADDR, 8'h00, q);
        `CHK("ictl stby", hmsp_pkg::HICTL_RESET, q)
        results();
    end
endmodule
`default_nettype wire

/* File: core/hmsp_port.sv */
// host mailbox status port: event fifo and the two-channel mailbox
`default_nettype none

module hmsp_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 4
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0] wr_ff, rd_ff, nxt_wr, nxt_rd;
    logic [AW:0] cnt_ff, nxt_cnt;
    logic push, pop;

    always_comb
    begin
        in_ready = (cnt_ff != (AW+1)'(DEPTH));
        out_valid = (cnt_ff != '0);
        out_data = mem_ff[rd_ff];
        push = in_valid & in_ready;
        pop = out_valid & out_ready;
        nxt_wr = wr_ff;
        nxt_rd = rd_ff;
        if (push)
        begin
            nxt_wr = (wr_ff == AW'(DEPTH-1)) ? '0 : wr_ff + 1'b1;
        end
        if (pop)
        begin
            nxt_rd = (rd_ff == AW'(DEPTH-1)) ? '0 : rd_ff + 1'b1;
        end
        nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            wr_ff <= '0;
            rd_ff <= '0;
            cnt_ff <= '0;
        end
        else if (clk_en)
        begin
            wr_ff <= nxt_wr;
            rd_ff <= nxt_rd;
            cnt_ff <= nxt_cnt;
            if (push)
            begin
                mem_ff[wr_ff] <= in_data;
            end
        end
    end
endmodule

module hmsp_port (
    input wire logic clock,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic standby,
    input wire hmsp_pkg::hmsp_sbus_t sbus,
    output logic [7:0] sl_rdata,
    input wire hmsp_pkg::hmsp_host_t host_pins,
    output logic [7:0] host_data_out,
    output logic host_data_oe,
    output logic host_port_active,
    output logic [1:0] in_full_irq
);
    function automatic logic hit(input logic [15:0] a, input logic [15:0] t);
        hit = (a == t);
    endfunction

    function automatic logic one_sel(input hmsp_pkg::hmsp_host_t h);
        one_sel = h.channel_one_select_n ^ h.channel_two_select_n;
    endfunction

    //----------------------------------------
    // host pin synchroniser
    //----------------------------------------
    hmsp_pkg::hmsp_host_t s1_ff, s2_ff, prev_ff;
    // two flops, then an edge stage
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            s1_ff <= '1;
            s2_ff <= '1;
            prev_ff <= '1;
        end
        else if (clk_en)
        begin
            s1_ff <= host_pins;
            s2_ff <= s1_ff;
            prev_ff <= s2_ff;
        end
    end

    //----------------------------------------
    // host strobe events
    //----------------------------------------
    logic port_en;
    logic wr_rise, rd_rise;
    logic pend_valid_ff, nxt_pend_valid;
    hmsp_pkg::hmsp_evt_t pend_ff, nxt_pend, drain;
    logic fifo_ready, drain_valid, drain_ready;

    always_comb
    begin
        // strobe qualifiers come from the held copy, stable over the edge
        // overlapped strobes are refused
        wr_rise = port_en & !prev_ff.wr_n & s2_ff.wr_n & one_sel(prev_ff)
            & prev_ff.rd_n;
        rd_rise = port_en & !prev_ff.rd_n & s2_ff.rd_n & one_sel(prev_ff)
            & !prev_ff.addr & prev_ff.wr_n;
        nxt_pend_valid = pend_valid_ff & !fifo_ready;
        nxt_pend = pend_ff;
        // capture byte on write strobe rise
        if (wr_rise && !nxt_pend_valid)
        begin
            nxt_pend_valid = 1'b1;
            nxt_pend.chan = prev_ff.channel_one_select_n;
            nxt_pend.cmd = prev_ff.addr;
            nxt_pend.data = prev_ff.data;
        end
        // hold off while the slave reads so a read sees one byte
        drain_ready = !sbus.rd;
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            pend_valid_ff <= 1'b0;
            pend_ff <= '0;
        end
        else if (clk_en)
        begin
            pend_valid_ff <= nxt_pend_valid;
            pend_ff <= nxt_pend;
        end
    end

    hmsp_fifo #(
        .WIDTH($bits(hmsp_pkg::hmsp_evt_t)),
        .DEPTH(hmsp_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clock(clock),
        .reset(reset),
        .clk_en(clk_en),
        .in_valid(pend_valid_ff),
        .in_ready(fifo_ready),
        .in_data(pend_ff),
        .out_valid(drain_valid),
        .out_ready(drain_ready),
        .out_data(drain)
    );

    //----------------------------------------
    // mailbox registers
    //----------------------------------------
    logic [7:0] sysctl_ff, nxt_sysctl, hictl_ff, nxt_hictl;
    logic [7:0] idr_ff [2], nxt_idr [2];
    logic [7:0] odr_ff [2], nxt_odr [2];
    logic [7:0] st_ff [2], nxt_st [2];
    logic [7:0] nxt_rdata, nxt_hdata;
    logic nxt_oe;
    logic [1:0] nxt_irq;
    logic gate_ok, sl_wr, sl_rd, ev_here;
    logic [15:0] in_a, out_a, st_a;

    assign port_en = sysctl_ff[hmsp_pkg::PORT_EN_BIT];

    always_comb
    begin
        gate_ok = port_en
            | (sbus.addr[15:4] != hmsp_pkg::GATED_PAGE);
        sl_wr = sbus.wr & gate_ok;
        sl_rd = sbus.rd & gate_ok;
        nxt_sysctl = sysctl_ff;
        nxt_hictl = hictl_ff;
        nxt_rdata = 8'h00;
        // port enable bit kept in system control
        if (sl_wr && hit(sbus.addr, hmsp_pkg::SYSCTL_ADDR))
        begin
            nxt_sysctl = (sbus.wdata & ~hmsp_pkg::SYSCTL_RO_MASK)
                | (sysctl_ff & hmsp_pkg::SYSCTL_RO_MASK);
        end
        if (sl_wr && hit(sbus.addr, hmsp_pkg::HICTL_ADDR))
        begin
            nxt_hictl = sbus.wdata | hmsp_pkg::HICTL_RSVD;
        end
        if (standby)
        begin
            nxt_hictl = hmsp_pkg::HICTL_RESET;
        end
        if (sl_rd && hit(sbus.addr, hmsp_pkg::SYSCTL_ADDR))
        begin
            nxt_rdata = sysctl_ff;
        end
        if (sl_rd && hit(sbus.addr, hmsp_pkg::HICTL_ADDR))
        begin
            nxt_rdata = hictl_ff;
        end
        for (int c = 0; c < 2; c++)
        begin
            in_a = (c == 0) ? hmsp_pkg::IN1_ADDR : hmsp_pkg::IN2_ADDR;
            out_a = (c == 0) ? hmsp_pkg::OUT1_ADDR : hmsp_pkg::OUT2_ADDR;
            st_a = (c == 0) ? hmsp_pkg::ST1_ADDR : hmsp_pkg::ST2_ADDR;
            ev_here = drain_valid & drain_ready & (drain.chan == 1'(c));
            nxt_idr[c] = idr_ff[c];
            nxt_odr[c] = odr_ff[c];
            nxt_st[c] = st_ff[c];
            // only user bits take slave writes
            if (sl_wr && hit(sbus.addr, st_a))
            begin
                nxt_st[c] = (sbus.wdata & hmsp_pkg::USER_MASK)
                    | (st_ff[c] & ~hmsp_pkg::USER_MASK);
            end
            // slave read of inbound clears full
            if (sl_rd && hit(sbus.addr, in_a))
            begin
                nxt_st[c][hmsp_pkg::IN_FULL_BIT] = 1'b0;
            end
            if (rd_rise && prev_ff.channel_one_select_n == 1'(c))
            begin
                nxt_st[c][hmsp_pkg::OUT_FULL_BIT] = 1'b0;
            end
            // outbound byte written by slave only
            if (sl_wr && hit(sbus.addr, out_a))
            begin
                nxt_odr[c] = sbus.wdata;
                nxt_st[c][hmsp_pkg::OUT_FULL_BIT] = 1'b1;
            end
            // inbound byte only loaded from host
            if (ev_here)
            begin
                nxt_idr[c] = drain.data;
                nxt_st[c][hmsp_pkg::CMD_BIT] = drain.cmd;
                nxt_st[c][hmsp_pkg::IN_FULL_BIT] = 1'b1;
            end
            if (standby)
            begin
                nxt_st[c] = hmsp_pkg::STATUS_RESET;
            end
            if (sl_rd && hit(sbus.addr, in_a))
            begin
                nxt_rdata = idr_ff[c];
            end
            if (sl_rd && hit(sbus.addr, out_a))
            begin
                nxt_rdata = odr_ff[c];
            end
            if (sl_rd && hit(sbus.addr, st_a))
            begin
                nxt_rdata = st_ff[c];
            end
            nxt_irq[c] = st_ff[c][hmsp_pkg::IN_FULL_BIT]
                & hictl_ff[hmsp_pkg::IRQ_EN_BASE + c];
        end
        // drive outbound byte or status (addr high) only while read held
        nxt_oe = port_en & !s2_ff.rd_n & s2_ff.wr_n & one_sel(s2_ff);
        nxt_hdata = s2_ff.addr ? st_ff[s2_ff.channel_one_select_n]
            : odr_ff[s2_ff.channel_one_select_n];
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            sysctl_ff <= hmsp_pkg::SYSCTL_RESET;
            hictl_ff <= hmsp_pkg::HICTL_RESET;
            st_ff[0] <= hmsp_pkg::STATUS_RESET;
            st_ff[1] <= hmsp_pkg::STATUS_RESET;
            sl_rdata <= 8'h00;
            host_data_out <= 8'h00;
            host_data_oe <= 1'b0;
            host_port_active <= 1'b0;
            in_full_irq <= 2'h0;
        end
        else if (clk_en)
        begin
            sysctl_ff <= nxt_sysctl;
            hictl_ff <= nxt_hictl;
            st_ff <= nxt_st;
            sl_rdata <= nxt_rdata;
            host_data_out <= nxt_hdata;
            host_data_oe <= nxt_oe;
            // claim the host lines once enabled
            host_port_active <= nxt_sysctl[hmsp_pkg::PORT_EN_BIT];
            in_full_irq <= nxt_irq;
        end
    end

    always_ff @(posedge clock)
    begin
        if (clk_en)
        begin
            idr_ff <= nxt_idr;
            odr_ff <= nxt_odr;
        end
    end

    //----------------------------------------
    // checks
    //----------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    sequence host_out1_read;
        clk_en && rd_rise && !prev_ff.channel_one_select_n && !standby
            && !(sl_wr && hit(sbus.addr, hmsp_pkg::OUT1_ADDR));
    endsequence

    sequence slave_st1_write;
        clk_en && sl_wr && hit(sbus.addr, hmsp_pkg::ST1_ADDR) && !standby;
    endsequence

    chk_user_bits_write: assert property (
        slave_st1_write |=> ((st_ff[0] & hmsp_pkg::USER_MASK)
            == ($past(sbus.wdata) & hmsp_pkg::USER_MASK)))
        else $error("user bits not written");
    chk_cmd_hw_only: assert property (
        $changed(st_ff[1][hmsp_pkg::CMD_BIT]) |->
            $past(standby || (drain_valid && drain_ready && drain.chan)))
        else $error("command flag changed without cause");
    chk_standby_clear: assert property (
        clk_en && standby |=> st_ff[0] == 8'h00 && st_ff[1] == 8'h00)
        else $error("status not cleared in standby");
    chk_cmd_capture: assert property (
        clk_en && drain_valid && drain_ready && !standby |=>
            st_ff[$past(drain.chan)][hmsp_pkg::CMD_BIT] == $past(drain.cmd))
        else $error("command flag mismatch");
    chk_in_full_set: assert property (
        clk_en && drain_valid && drain_ready && !standby |=>
            st_ff[$past(drain.chan)][hmsp_pkg::IN_FULL_BIT])
        else $error("input full not set");
    chk_in_full_clear: assert property (
        clk_en && sl_rd && hit(sbus.addr, hmsp_pkg::IN2_ADDR) |=>
            !st_ff[1][hmsp_pkg::IN_FULL_BIT])
        else $error("input full not cleared");
    chk_out_full_set: assert property (
        clk_en && sl_wr && hit(sbus.addr, hmsp_pkg::OUT2_ADDR) && !standby
            |=> st_ff[1][hmsp_pkg::OUT_FULL_BIT])
        else $error("output full not set");
    chk_out_full_clear: assert property (
        host_out1_read |=> !st_ff[0][hmsp_pkg::OUT_FULL_BIT])
        else $error("output full not cleared");
    chk_drive_window: assert property (
        clk_en && port_en && !s2_ff.rd_n && s2_ff.wr_n
            && !s2_ff.channel_two_select_n && s2_ff.channel_one_select_n
            && !s2_ff.addr
            |=> host_data_oe && host_data_out == $past(odr_ff[1]))
        else $error("outbound byte not driven");
    chk_port_gated: assert property (
        clk_en && !port_en |=> !host_data_oe)
        else $error("host port drives while disabled");
    chk_irq_gate: assert property (
        clk_en |=> in_full_irq[0] == $past(st_ff[0][hmsp_pkg::IN_FULL_BIT]
            & hictl_ff[hmsp_pkg::IRQ_EN_BASE]))
        else $error("interrupt gating wrong");
endmodule
`default_nettype wire

/* File: core/hmsp_port_notes_unused.sv */
// holds no logic: the whole port lives in hmsp_port
`default_nettype none
`default_nettype wire

/* File: inc/hmsp_pkg.sv */
// constants and carriers shared by the host mailbox status port
`default_nettype none
package hmsp_pkg;
    // slave-side register addresses
    localparam logic [15:0] SYSCTL_ADDR = 16'hFFC4;
    localparam logic [15:0] HICTL_ADDR = 16'hFFF0;
    localparam logic [15:0] IN1_ADDR = 16'hFFF4;
    localparam logic [15:0] OUT1_ADDR = 16'hFFF5;
    localparam logic [15:0] ST1_ADDR = 16'hFFF6;
    localparam logic [15:0] IN2_ADDR = 16'hFFFC;
    localparam logic [15:0] OUT2_ADDR = 16'hFFFD;
    localparam logic [15:0] ST2_ADDR = 16'hFFFE;
    // window that only answers while the port is enabled
    localparam logic [11:0] GATED_PAGE = 12'hFFF;
    // reset values and masks
    localparam logic [7:0] SYSCTL_RESET = 8'h09;
    localparam logic [7:0] SYSCTL_RO_MASK = 8'h08;
    localparam logic [7:0] HICTL_RESET = 8'hF8;
    localparam logic [7:0] HICTL_RSVD = 8'hF8;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] USER_MASK = 8'hF4;
    // field positions and fifo depth
    localparam int PORT_EN_BIT = 1;
    localparam int IRQ_EN_BASE = 1;
    localparam int CMD_BIT = 3;
    localparam int IN_FULL_BIT = 1;
    localparam int OUT_FULL_BIT = 0;
    localparam int FIFO_DEPTH = 4;

    typedef struct packed {
        logic rd_n;
        logic wr_n;
        logic channel_one_select_n;
        logic channel_two_select_n;
        logic addr;
        logic [7:0] data;
    } hmsp_host_t;

    typedef struct packed {
        logic chan;
        logic cmd;
        logic [7:0] data;
    } hmsp_evt_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [15:0] addr;
        logic [7:0] wdata;
    } hmsp_sbus_t;
endpackage
`default_nettype wire
